// ### cal_divider_check.sv
`timescale 1ns/1ns
`default_nettype none
module cal_divider_check
    import loop_regs_pkg::*;
(
    input wire logic [1:0] a_word_i,
    input wire logic [5:0] b_word_i,
    output logic legal_o
);
    logic [7:0] n_value;
    logic in_range;
    logic a_fits;

    // N is formed as four times B plus A; it fits in eight bits by construction.
    assign n_value = {b_word_i, a_word_i};
    assign in_range = (n_value >= CAL_N_MIN) && (n_value <= CAL_N_MAX);
    // Small B values cannot absorb every A step in the prescaler.
    assign a_fits = (b_word_i == CAL_B_FOUR) ? (a_word_i <= 2'h1) :
                    (b_word_i <= CAL_B_SIX) ? (a_word_i <= 2'h2) : 1'b1;
    assign legal_o = in_range && a_fits;
endmodule
`default_nettype wire

// ### loop_control_regs.sv
`timescale 1ns/1ns
`default_nettype none
module loop_control_regs
    import loop_regs_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic ref_choice_pin_i,
    input wire logic primary_reference_ok_i,
    input wire logic secondary_reference_ok_i,
    input wire logic feedback_clock_ok_i,
    output first_loop_ctrl_type first_stage_loop_o,
    output second_loop_ctrl_type second_stage_loop_o
);
    typedef enum logic [1:0] {
        st_on_primary,
        st_on_secondary,
        st_holdover
    } sel_state_type;

    // Reset release: asserted at once, released through two flops.
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Register storage.
    logic [7:0] ref_select_holdover_q;
    logic [7:0] first_loop_fast_lock_q;
    logic [7:0] second_loop_pump_current_q;
    logic [7:0] calibration_feedback_divider_q;
    logic [7:0] second_loop_control_q;

    // Address decode for both directions.
    wire hit_rsh = addr_hit(reg_addr_i, REF_SELECT_HOLDOVER_ADDR);
    wire hit_fl = addr_hit(reg_addr_i, FIRST_LOOP_FAST_LOCK_ADDR);
    wire hit_pc = addr_hit(reg_addr_i, SECOND_LOOP_PUMP_CURRENT_ADDR);
    wire hit_cd = addr_hit(reg_addr_i, CALIBRATION_FEEDBACK_DIVIDER_ADDR);
    wire hit_ctl = addr_hit(reg_addr_i, SECOND_LOOP_CONTROL_ADDR);

    // Reserved bits are dropped on the way in, so they always hold zero.
    wire [7:0] wdata_rsh = reg_wdata_i & REF_SELECT_HOLDOVER_MASK;
    wire [7:0] wdata_ctl = reg_wdata_i & SECOND_LOOP_CONTROL_MASK;

    // Writes to unmapped offsets are ignored.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ref_select_holdover_q <= REF_SELECT_HOLDOVER_RST;
            first_loop_fast_lock_q <= FIRST_LOOP_FAST_LOCK_RST;
            second_loop_pump_current_q <= SECOND_LOOP_PUMP_CURRENT_RST;
            calibration_feedback_divider_q <= CALIBRATION_FEEDBACK_DIVIDER_RST;
            second_loop_control_q <= SECOND_LOOP_CONTROL_RST;
        end else if (reg_write_i) begin
            if (hit_rsh) begin
                ref_select_holdover_q <= wdata_rsh;
            end
            if (hit_fl) begin
                first_loop_fast_lock_q <= reg_wdata_i & FULL_MASK;
            end
            if (hit_pc) begin
                second_loop_pump_current_q <= reg_wdata_i & FULL_MASK;
            end
            if (hit_cd) begin
                calibration_feedback_divider_q <= reg_wdata_i & FULL_MASK;
            end
            if (hit_ctl) begin
                second_loop_control_q <= wdata_ctl;
            end
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    wire [7:0] rd_mux = hit_rsh ? ref_select_holdover_q :
                        hit_fl ? first_loop_fast_lock_q :
                        hit_pc ? second_loop_pump_current_q :
                        hit_cd ? calibration_feedback_divider_q :
                        hit_ctl ? second_loop_control_q : 8'h00;

    // Read data is returned one cycle after the request and then held.
    logic [7:0] rdata_q;
    logic rvalid_q;

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_read_i;
            if (reg_read_i) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;

    // Pin and monitor inputs come from outside this clock domain.
    logic [3:0] pins_sync;

    pin_sync3 #(
        .WIDTH(4)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .async_i({feedback_clock_ok_i, secondary_reference_ok_i,
                  primary_reference_ok_i, ref_choice_pin_i}),
        .level_o(pins_sync)
    );

    wire choice_pin = pins_sync[0];
    wire primary_ok = pins_sync[1];
    wire secondary_ok = pins_sync[2];
    wire feedback_ok = pins_sync[3];

    // Mode field fields.
    wire [1:0] mode_low = ref_select_holdover_q[REF_MODE_LSB +: 2];
    wire pin_mode = ref_select_holdover_q[REF_MODE_PIN_BIT];
    wire holdover_mid = ref_select_holdover_q[HOLDOVER_BIT];

    // Reference selection state.
    sel_state_type state_q;
    sel_state_type state_d;
    logic last_secondary_q;

    wire cur_secondary = (state_q == st_on_secondary) ||
                         ((state_q == st_holdover) && last_secondary_q);
    wire cur_ok = cur_secondary ? secondary_ok : primary_ok;
    wire other_ok = cur_secondary ? primary_ok : secondary_ok;

    // Automatic modes stay on a healthy reference and only move on a loss;
    // the revertive one also returns to the primary as soon as it is healthy.
    wire auto_pick = ((mode_low == REF_MODE_REVERT) && primary_ok) ? 1'b0 :
                     cur_ok ? cur_secondary :
                     other_ok ? !cur_secondary : cur_secondary;

    // Forced codes ignore the pin; the pin bit ignores the low code bits.
    wire forced_pick = (mode_low == REF_MODE_FORCE_SECONDARY);
    wire is_forced = (mode_low == REF_MODE_FORCE_PRIMARY) ||
                     (mode_low == REF_MODE_FORCE_SECONDARY);
    wire pick_secondary = pin_mode ? choice_pin :
                          is_forced ? forced_pick : auto_pick;
    wire pick_ok = pick_secondary ? secondary_ok : primary_ok;

    // Holdover is entered whenever the chosen input or the feedback is lost.
    wire clocks_failed = !pick_ok || !feedback_ok;

    always_comb begin
        state_d = state_q;
        case (state_q)
            st_on_primary, st_on_secondary, st_holdover: begin
                if (clocks_failed) begin
                    state_d = st_holdover;
                end else if (pick_secondary) begin
                    state_d = st_on_secondary;
                end else begin
                    state_d = st_on_primary;
                end
            end
            default: begin
                state_d = st_on_primary;
            end
        endcase
    end

    // The last reference in use is kept through holdover for a clean return.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= st_on_primary;
            last_secondary_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (!clocks_failed) begin
                last_secondary_q <= pick_secondary;
            end
        end
    end

    // Calibration divider legality, shown to the analog side.
    wire [1:0] cal_a = calibration_feedback_divider_q[CAL_A_LSB +: 2];
    wire [5:0] cal_b = calibration_feedback_divider_q[CAL_B_LSB +: 6];
    logic cal_legal;

    cal_divider_check u_cal_check (
        .a_word_i(cal_a),
        .b_word_i(cal_b),
        .legal_o(cal_legal)
    );

    // Control decode for both loops.
    wire in_holdover = (state_q == st_holdover);
    wire [1:0] pump_mode = second_loop_control_q[PUMP_MODE_LSB +: 2];
    first_loop_ctrl_type first_d;
    second_loop_ctrl_type second_d;

    assign first_d.use_secondary = cur_secondary;
    assign first_d.holdover_active = in_holdover;
    assign first_d.tuning_force_mid = in_holdover && holdover_mid;
    assign first_d.pump_tristate = in_holdover && !holdover_mid;
    assign first_d.fast_lock_enable = first_loop_fast_lock_q[FAST_LOCK_EN_BIT];
    assign first_d.pump_current = first_loop_fast_lock_q[FIRST_PUMP_CURRENT_LSB +: 7];
    assign second_d.pump_current = second_loop_pump_current_q;
    assign second_d.cal_a = cal_a;
    assign second_d.cal_b = cal_b;
    assign second_d.cal_legal = cal_legal;
    assign second_d.lock_detect_powerdown = second_loop_control_q[LOCK_DETECT_PD_BIT];
    assign second_d.doubler_enable = second_loop_control_q[DOUBLER_EN_BIT];
    assign second_d.pump_tristate = (pump_mode == PUMP_MODE_TRISTATE);
    assign second_d.pump_down = (pump_mode == PUMP_MODE_DOWN);
    assign second_d.pump_up = (pump_mode == PUMP_MODE_UP);

    // Controls leave through flops so the analog side sees no decode glitches,
    // at the cost of one cycle of latency after each register write.
    first_loop_ctrl_type first_q;
    second_loop_ctrl_type second_q;

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            first_q <= '0;
            second_q <= '0;
        end else begin
            first_q <= first_d;
            second_q <= second_d;
        end
    end

    assign first_stage_loop_o = first_q;
    assign second_stage_loop_o = second_q;
endmodule
`default_nettype wire

// ### loop_control_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module loop_control_regs_checker
    import loop_regs_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic ref_choice_pin_i,
    input wire logic primary_reference_ok_i,
    input wire logic secondary_reference_ok_i,
    input wire logic feedback_clock_ok_i,
    input wire first_loop_ctrl_type first_stage_loop_o,
    input wire second_loop_ctrl_type second_stage_loop_o
);
    // Own decode and legality sum, so a shared slip in the design cannot hide itself.
    wire logic mapped = reg_addr_i inside {16'h010A, 16'h010B, 16'h0200, 16'h0201, 16'h0202};
    wire logic [1:0] a = second_stage_loop_o.cal_a;
    wire logic [5:0] b = second_stage_loop_o.cal_b;
    wire logic legal = b >= 6'h04 && !(b == 6'h04 && a > 2'h1) && !(b inside {6'h05, 6'h06} && a == 2'h3);
    wire logic wr_ctrl = reg_write_i && reg_addr_i == 16'h0202;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_read_valid_pulse: assert property (reg_rvalid_o == $past(reg_read_i))
        else $error("read valid does not trail the read strobe by one cycle");
    a_unmapped_reads_zero: assert property (reg_read_i && !mapped |=> reg_rdata_o == 8'h00)
        else $error("unmapped read returned nonzero data");
    a_select_upper_zero: assert property (reg_read_i && reg_addr_i == 16'h010A |=> reg_rdata_o[7:4] == 4'h0)
        else $error("reserved selection bits read nonzero");
    a_control_reserved_zero: assert property (reg_read_i && reg_addr_i == 16'h0202 |=> reg_rdata_o[6:2] ==? 5'b0X000)
        else $error("reserved control bits read nonzero");
    a_fast_lock_fields: assert property (reg_write_i && reg_addr_i == 16'h010B |-> ##2 {first_stage_loop_o.fast_lock_enable, first_stage_loop_o.pump_current} == $past(reg_wdata_i, 2))
        else $error("fast lock fields do not follow the written byte");
    a_second_pump_current: assert property (reg_write_i && reg_addr_i == 16'h0200 |-> ##2 second_stage_loop_o.pump_current == $past(reg_wdata_i, 2))
        else $error("second pump current does not follow the written byte");
    a_divider_words: assert property (reg_write_i && reg_addr_i == 16'h0201 |-> ##2 {a, b} == $past(reg_wdata_i, 2))
        else $error("divider words do not follow the written byte");
    a_divider_legal: assert property (second_stage_loop_o.cal_legal == legal)
        else $error("divider legality flag is wrong");
    a_control_decode: assert property (wr_ctrl |-> ##2 second_stage_loop_o.lock_detect_powerdown == $past(reg_wdata_i[7], 2) && second_stage_loop_o.doubler_enable == $past(reg_wdata_i[5], 2))
        else $error("detector or doubler bit does not follow the write");
    a_pump_mode_decode: assert property (wr_ctrl |-> ##2 {second_stage_loop_o.pump_tristate, second_stage_loop_o.pump_down, second_stage_loop_o.pump_up} == 3'b100 >> $past(reg_wdata_i[1:0], 2))
        else $error("pump mode decode is wrong");
    a_holdover_one_drive: assert property (first_stage_loop_o.holdover_active |-> first_stage_loop_o.tuning_force_mid != first_stage_loop_o.pump_tristate)
        else $error("holdover drives both or neither of mid supply and tristate");

    c_control_write: cover property (wr_ctrl);
    c_holdover_mid: cover property (first_stage_loop_o.holdover_active && first_stage_loop_o.tuning_force_mid);
    c_unmapped_read: cover property (reg_read_i && !mapped);
endmodule
`default_nettype wire

// ### loop_regs_pkg.sv
// Contract
// - Holdover bit 1 forces tuning voltage to midsupply on clock failure, else pump tristates.
// - Three-bit reference selection mode field, resetting to 000.
// - Top bit 0: nonrevertive, revert-to-primary, force primary, force secondary; pin ignored.
// - Top bit 1: follow choice pin, low primary, high secondary.
// - Fast-lock register top bit enables first-stage fast lock.
// - Seven-bit first-stage pump current field, about 0.5 uA steps.
// - Eight-bit second-stage pump current register, about 3.5 uA steps.
// - Calibration divider: A word in bits 7:6, B word in bits 5:0.
// - N equals 4B plus A, 16 to 255, with A limited by B.
// - Control bit 7 high powers down second-stage lock detector.
// - Doubler bit 1 doubles second-stage reference, 0 passes it undoubled.
// - Pump mode: 00 tristate, 01 down, 10 up, 11 normal by default.
package loop_regs_pkg;

    localparam int ADDR_W = 16;

    // Register offsets on the serial control port.
    localparam logic [15:0] REF_SELECT_HOLDOVER_ADDR = 16'h010A;
    localparam logic [15:0] FIRST_LOOP_FAST_LOCK_ADDR = 16'h010B;
    localparam logic [15:0] SECOND_LOOP_PUMP_CURRENT_ADDR = 16'h0200;
    localparam logic [15:0] CALIBRATION_FEEDBACK_DIVIDER_ADDR = 16'h0201;
    localparam logic [15:0] SECOND_LOOP_CONTROL_ADDR = 16'h0202;

    // Reset values.
    localparam logic [7:0] REF_SELECT_HOLDOVER_RST = 8'h00;
    localparam logic [7:0] FIRST_LOOP_FAST_LOCK_RST = 8'h00;
    localparam logic [7:0] SECOND_LOOP_PUMP_CURRENT_RST = 8'h00;
    localparam logic [7:0] CALIBRATION_FEEDBACK_DIVIDER_RST = 8'h00;
    localparam logic [7:0] SECOND_LOOP_CONTROL_RST = 8'h03;

    // Implemented bits of each register; the others are reserved.
    localparam logic [7:0] REF_SELECT_HOLDOVER_MASK = 8'h0F;
    localparam logic [7:0] FULL_MASK = 8'hFF;
    localparam logic [7:0] SECOND_LOOP_CONTROL_MASK = 8'hA3;

    // Field positions.
    localparam int HOLDOVER_BIT = 3;
    localparam int REF_MODE_LSB = 0;
    localparam int REF_MODE_PIN_BIT = 2;
    localparam int FAST_LOCK_EN_BIT = 7;
    localparam int FIRST_PUMP_CURRENT_LSB = 0;
    localparam int CAL_A_LSB = 6;
    localparam int CAL_B_LSB = 0;
    localparam int LOCK_DETECT_PD_BIT = 7;
    localparam int DOUBLER_EN_BIT = 5;
    localparam int PUMP_MODE_LSB = 0;

    // Reference selection mode codes with the pin bit clear.
    localparam logic [1:0] REF_MODE_NONREVERT = 2'h0;
    localparam logic [1:0] REF_MODE_REVERT = 2'h1;
    localparam logic [1:0] REF_MODE_FORCE_PRIMARY = 2'h2;
    localparam logic [1:0] REF_MODE_FORCE_SECONDARY = 2'h3;

    // Second-stage pump mode codes.
    localparam logic [1:0] PUMP_MODE_TRISTATE = 2'h0;
    localparam logic [1:0] PUMP_MODE_DOWN = 2'h1;
    localparam logic [1:0] PUMP_MODE_UP = 2'h2;
    localparam logic [1:0] PUMP_MODE_NORMAL = 2'h3;

    // Legal calibration feedback division range.
    localparam logic [7:0] CAL_N_MIN = 8'h10;
    localparam logic [7:0] CAL_N_MAX = 8'hFF;
    localparam logic [5:0] CAL_B_FOUR = 6'h04;
    localparam logic [5:0] CAL_B_SIX = 6'h06;

    typedef struct packed {
        logic use_secondary;
        logic holdover_active;
        logic tuning_force_mid;
        logic pump_tristate;
        logic fast_lock_enable;
        logic [6:0] pump_current;
    } first_loop_ctrl_type;

    typedef struct packed {
        logic [7:0] pump_current;
        logic [1:0] cal_a;
        logic [5:0] cal_b;
        logic cal_legal;
        logic lock_detect_powerdown;
        logic doubler_enable;
        logic pump_tristate;
        logic pump_down;
        logic pump_up;
    } second_loop_ctrl_type;

    // Address compare shared by the write and read decoders.
    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] reg_addr);
        addr_hit = (addr == reg_addr);
    endfunction

endpackage

// ### pin_sync3.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync3
    import loop_regs_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] mid_q;
    logic [WIDTH-1:0] last_q;
    logic [WIDTH-1:0] level_q;

    // Three stages; a bit only changes once stages two and three agree, so a
    // single-cycle glitch on a pin never reaches the selection logic.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            mid_q <= '0;
            last_q <= '0;
            level_q <= '0;
        end else begin
            meta_q <= async_i;
            mid_q <= meta_q;
            last_q <= mid_q;
            level_q <= (mid_q & last_q) | (level_q & (mid_q | last_q));
        end
    end

    assign level_o = level_q;
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
    import loop_regs_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic ref_choice_pin_i = 1'b0;
    logic primary_reference_ok_i = 1'b1;
    logic secondary_reference_ok_i = 1'b1;
    logic feedback_clock_ok_i = 1'b1;
    logic [7:0] rdata;
    logic rvalid;
    first_loop_ctrl_type fl;
    second_loop_ctrl_type sl;
    int n_mismatch = 0;
    int samples_checked = 0;
    // The last address is unmapped; expected read-back drops the reserved bits.
    logic [15:0] addrs [6] = '{16'h010A, 16'h010B, 16'h0200, 16'h0201, 16'h0202, 16'h0203};
    logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
    logic [7:0] wvals [6] = '{8'hFF, 8'hA5, 8'hFF, 8'hC7, 8'hFF, 8'h55};
    logic [7:0] rbk [6] = '{8'h0F, 8'hA5, 8'hFF, 8'hC7, 8'hA3, 8'h00};
    logic [7:0] cal [8] = '{8'h44, 8'h84, 8'h85, 8'hC6, 8'hC7, 8'hC3, 8'h04, 8'h86};
    logic [7:0] legal = 8'hD5;

    loop_control_regs loop_control_regs_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .ref_choice_pin_i(ref_choice_pin_i), .primary_reference_ok_i(primary_reference_ok_i),
        .secondary_reference_ok_i(secondary_reference_ok_i),
        .feedback_clock_ok_i(feedback_clock_ok_i), .first_stage_loop_o(fl),
        .second_stage_loop_o(sl));

    // Clock at 50 MHz.
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    // A write is left two edges to reach the outputs before the task returns.
    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        reg_write_i = 1'b1;
        reg_addr_i = addr;
        reg_wdata_i = data;
        @(negedge clk_i);
        reg_write_i = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic rd(input logic [15:0] addr, input logic [7:0] exp, input string what);
        @(negedge clk_i);
        reg_read_i = 1'b1;
        reg_addr_i = addr;
        @(negedge clk_i);
        reg_read_i = 1'b0;
        check(rvalid, 1'b1, "read valid");
        check(rdata, exp, what);
    endtask

    // Eight cycles cover the four-flop pin synchroniser plus state and output stages.
    task automatic refcase(input logic [7:0] val, input logic pin, input logic pok,
                           input logic sec, input logic hold);
        ref_choice_pin_i = pin;
        primary_reference_ok_i = pok;
        wr(16'h010A, val);
        repeat (8) @(negedge clk_i);
        check(fl.use_secondary, sec, "reference choice");
        check({fl.holdover_active, fl.tuning_force_mid, fl.pump_tristate}, {hold, hold & val[3], hold & ~val[3]}, "holdover drive");
    endtask

    task automatic end_of_test();
        $display("Counts: %0d checked, %0d mismatched", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (10) @(negedge clk_i);
        foreach (addrs[i]) rd(addrs[i], rstv[i], "reset value");
        check({sl.pump_tristate, sl.pump_down, sl.pump_up}, 3'b000, "default pump mode");
        $display("test reset_values done");
        refcase(8'h09, 1'b0, 1'b1, 1'b0, 1'b0);
        refcase(8'h08, 1'b0, 1'b0, 1'b1, 1'b0);
        refcase(8'h08, 1'b0, 1'b1, 1'b1, 1'b0);
        refcase(8'h09, 1'b0, 1'b1, 1'b0, 1'b0);
        refcase(8'h0A, 1'b1, 1'b1, 1'b0, 1'b0);
        refcase(8'h0B, 1'b0, 1'b1, 1'b1, 1'b0);
        refcase(8'h0C, 1'b1, 1'b1, 1'b1, 1'b0);
        refcase(8'h0F, 1'b0, 1'b1, 1'b0, 1'b0);
        refcase(8'h0A, 1'b0, 1'b0, 1'b0, 1'b1);
        refcase(8'h02, 1'b0, 1'b0, 1'b0, 1'b1);
        $display("test reference_select done");
        foreach (addrs[i]) wr(addrs[i], wvals[i]);
        foreach (addrs[i]) rd(addrs[i], rbk[i], "read back");
        check({fl.fast_lock_enable, fl.pump_current}, 8'hA5, "fast lock fields");
        check(sl.pump_current, 8'hFF, "second pump current");
        $display("test register_access done");
        for (int m = 0; m < 4; m++) begin
            wr(16'h0202, {m[1], 1'b0, m[0], 3'b000, m[1:0]});
            check({sl.pump_tristate, sl.pump_down, sl.pump_up}, 3'b100 >> m, "pump mode");
            check({sl.lock_detect_powerdown, sl.doubler_enable}, m[1:0], "detector and doubler");
        end
        $display("test control_modes done");
        foreach (cal[i]) begin
            wr(16'h0201, cal[i]);
            check({sl.cal_a, sl.cal_b}, cal[i], "divider words");
            check(sl.cal_legal, legal[i], "divider legality");
        end
        $display("test divider_words done");
        end_of_test();
    end

    // The tests take well under a thousand cycles; ten thousand means a hang.
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule

bind loop_control_regs loop_control_regs_checker loop_control_regs_checker_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .ref_choice_pin_i(ref_choice_pin_i),
    .primary_reference_ok_i(primary_reference_ok_i),
    .secondary_reference_ok_i(secondary_reference_ok_i),
    .feedback_clock_ok_i(feedback_clock_ok_i), .first_stage_loop_o(first_stage_loop_o),
    .second_stage_loop_o(second_stage_loop_o));
`default_nettype wire
